/* hw/pcs_lane_coding.sv */
// Purpose: 64b/66b coding with lane markers
// Assumes: one aclk, 66-bit parallel line blocks
// Notes: AXI4-Lite registers, no FEC codec
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`include "pcs_params.svh"
`timescale 1ns/1ps
module pcs_lane_coding (
  // Clock, reset and enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // Transceiver full reset pin
  input  wire logic                   transceiver_reset_everything,
  // AXI4-Lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Transmit client
  input  wire pcs_pkg::pcs_mii_t      tx_mii_word,
  input  wire logic                   tx_mii_valid,
  output logic                        tx_mii_ready,
  // Receive client
  output pcs_pkg::pcs_mii_t           rx_mii_word,
  output logic                        rx_mii_valid,
  input  wire logic                   rx_mii_ready,
  // Line lanes
  output pcs_pkg::pcs_blk_t [1:0]     transmit_serial_lane_p,
  output pcs_pkg::pcs_blk_t [1:0]     transmit_serial_lane_n,
  output logic                        transmit_lane_valid,
  input  wire pcs_pkg::pcs_blk_t [1:0] receive_serial_lane_p,
  input  wire pcs_pkg::pcs_blk_t [1:0] receive_serial_lane_n,
  input  wire logic                   receive_lane_valid,
  // Status
  output logic [3:0]                  block_lock,
  output logic                        rx_fifo_error,
  output logic                        startup_done,
  output logic [1:0]                  an_fec_advertise
);
  import pcs_pkg::*;

  logic [31:0] ctrl_reg;
  logic [15:0] receive_marker_spacing_reg;
  logic [15:0] transmit_marker_spacing_reg;
  logic [63:0] receive_lane_marker_value_reg  [0:3];
  logic [63:0] transmit_lane_marker_value_reg [0:3];
  pcs_start_t  st_reg;
  logic [7:0]  st_cnt_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic [15:0] tx_cnt_reg;
  logic [15:0] rx_cnt_reg;
  logic        wr_fire;
  logic [31:0] rd_mux;
  pcs_fec_t    fec;
  logic        rs50;
  pcs_blk_t    tx_blk [0:1];
  logic [15:0] tx_space;
  logic [15:0] rx_space;
  logic        xcvr_rst;
  logic        tx_rst;
  logic        rx_rst;
  logic        rx_cli_rst;
  logic        tx_mark;
  logic        rx_mark;
  logic        rx_go;
  logic        rx_new;
  pcs_mii_t    buf_word;
  logic        buf_valid;
  logic [71:0] dec0;
  logic [71:0] dec1;

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Mapped addresses answer OKAY
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[7:6] == `PCS_MK_PAGE) || (a == `PCS_OFF_CTRL) ||
           (a == `PCS_OFF_SPACE) || (a == `PCS_OFF_STAT);
  endfunction

  // Mode field, code 3 falls back to no FEC
  function automatic pcs_fec_t fec_of(input logic [1:0] f);
    unique case (f)
      2'h1:    return PCS_FEC_CYCLIC;
      2'h2:    return PCS_FEC_RS;
      default: return PCS_FEC_NONE;
    endcase
  endfunction

  // One 8-byte word to a 66-bit block
  function automatic pcs_blk_t enc64(input logic [63:0] d, input logic [7:0] c);
    pcs_blk_t    b;
    logic [63:0] m;
    logic [63:0] tt;
    tt = `PCS_T_TERM;
    b = {`PCS_SYNC_CTRL, {8{`PCS_C_ERR}}, `PCS_T_IDLE};
    if (c == 8'h00) begin
      b = {`PCS_SYNC_DATA, d};
    end else if (c == 8'hFF && d == {8{`PCS_CH_IDLE}}) begin
      b = `PCS_IDLE_BLK;
    end else if (c == 8'h01 && d[7:0] == `PCS_CH_START) begin
      b = {`PCS_SYNC_CTRL, d[63:8], `PCS_T_START};
    end else begin
      for (int k = 0; k < 8; k++) begin
        m = 64'hFFFF_FFFF_FFFF_FFFF << (8 * k);
        if (c == (8'hFF << k) && d[8*k +: 8] == `PCS_CH_TERM &&
            ((d ^ {8{`PCS_CH_IDLE}}) & (m << 8)) == 64'h0) begin
          b = {`PCS_SYNC_CTRL, d[55:0] & ~m[55:0], tt[8*k +: 8]};
        end
      end
    end
    return b;
  endfunction

  // One 66-bit block to {data, control}
  function automatic logic [71:0] dec64(input pcs_blk_t b);
    logic [63:0] d;
    logic [7:0]  c;
    logic [63:0] m;
    logic [63:0] tt;
    tt = `PCS_T_TERM;
    d = {8{`PCS_CH_ERR}};
    c = 8'hFF;
    if (b[65:64] == `PCS_SYNC_DATA) begin
      d = b[63:0];
      c = 8'h00;
    end else if (b[65:64] == `PCS_SYNC_CTRL) begin
      if (b == `PCS_IDLE_BLK) begin
        d = {8{`PCS_CH_IDLE}};
      end else if (b[7:0] == `PCS_T_START) begin
        d = {b[63:8], `PCS_CH_START};
        c = 8'h01;
      end else begin
        for (int k = 0; k < 8; k++) begin
          if (b[7:0] == tt[8*k +: 8]) begin
            m = 64'hFFFF_FFFF_FFFF_FFFF << (8 * k);
            d = ({8'h00, b[63:8]} & ~m) | ({8{`PCS_CH_IDLE}} & (m << 8)) |
                (64'(`PCS_CH_TERM) << (8 * k));
            c = 8'hFF << k;
          end
        end
      end
    end
    return {d, c};
  endfunction

  // Mode, spacing and reset derivation
  assign fec        = fec_of(ctrl_reg[1:0]); // R1 R16
  assign rs50       = (fec == PCS_FEC_RS) && ctrl_reg[`PCS_CTRL_50G];
  assign tx_space   = rs50 ? `PCS_SPACE_RS50 : transmit_marker_spacing_reg; // R11
  assign rx_space   = rs50 ? `PCS_SPACE_RS50 : receive_marker_spacing_reg; // R11
  assign xcvr_rst   = transceiver_reset_everything | ctrl_reg[`PCS_CTRL_XRST];
  assign tx_rst     = ctrl_reg[`PCS_CTRL_TXCORE] | ~startup_done; // R7 R14
  assign rx_rst     = ctrl_reg[`PCS_CTRL_RXCORE] | ~startup_done; // R7 R14
  assign rx_cli_rst = ctrl_reg[`PCS_CTRL_RXCLI] | rx_rst; // R9
  assign tx_mark    = (tx_cnt_reg < 16'h0002);
  assign rx_mark    = (rx_cnt_reg < 16'h0002);
  assign rx_go      = ~rx_rst & receive_lane_valid;
  assign rx_new     = rx_go & ~rx_mark;
  assign wr_fire    = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign dec0       = dec64(receive_serial_lane_p[0]); // R3
  assign dec1       = dec64(receive_serial_lane_p[1]); // R3

  // Transmit buffer, flushed by resets
  pcs_pair_buf u_txbuf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .flush     (ctrl_reg[`PCS_CTRL_TXCLI] | tx_rst), // R9
    .in_word   (tx_mii_word), // R6
    .in_valid  (tx_mii_valid),
    .in_ready  (tx_mii_ready),
    .out_word  (buf_word),
    .out_valid (buf_valid),
    .out_ready (~tx_rst & ~tx_mark)
  );

  // Transceiver startup sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= PCS_ST_HOLD;
      st_cnt_reg   <= 8'h00;
      startup_done <= 1'b0;
    end else if (ce) begin
      if (xcvr_rst) begin
        st_reg       <= PCS_ST_HOLD; // R7
        startup_done <= 1'b0; // R7
      end else begin
        unique case (st_reg)
          PCS_ST_HOLD: begin
            st_reg     <= PCS_ST_WAIT;
            st_cnt_reg <= 8'h00;
          end
          PCS_ST_WAIT: begin
            if (st_cnt_reg == 8'(`PCS_STARTUP_CYC - 1)) begin
              st_reg       <= PCS_ST_RUN;
              startup_done <= 1'b1;
            end else begin
              st_cnt_reg <= st_cnt_reg + 8'h01;
            end
          end
          PCS_ST_RUN: startup_done <= 1'b1;
        endcase
      end
    end
  end

  // Write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCS_RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_reg) ? `PCS_RESP_OK : `PCS_RESP_SLV;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and spacing registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg                    <= `PCS_CTRL_RST;
      receive_marker_spacing_reg  <= `PCS_SPACE_DEF; // R10
      transmit_marker_spacing_reg <= `PCS_SPACE_DEF; // R10
    end else if (ce && wr_fire) begin
      if (aw_addr_reg == `PCS_OFF_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & `PCS_CTRL_MASK;
      end else if (aw_addr_reg == `PCS_OFF_SPACE) begin
        {transmit_marker_spacing_reg, receive_marker_spacing_reg} <=
          merge({transmit_marker_spacing_reg, receive_marker_spacing_reg},
                w_data_reg, w_strb_reg); // R10
      end
    end
  end

  // Marker registers, two words each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        receive_lane_marker_value_reg[i]  <= 64'h0;
        transmit_lane_marker_value_reg[i] <= 64'h0;
      end
    end else if (ce && wr_fire && aw_addr_reg[7:6] == `PCS_MK_PAGE) begin
      if (aw_addr_reg[5]) begin
        transmit_lane_marker_value_reg[aw_addr_reg[4:3]][32*aw_addr_reg[2] +: 32] <=
          merge(transmit_lane_marker_value_reg[aw_addr_reg[4:3]][32*aw_addr_reg[2] +: 32],
                w_data_reg, w_strb_reg); // R13
      end else begin
        receive_lane_marker_value_reg[aw_addr_reg[4:3]][32*aw_addr_reg[2] +: 32] <=
          merge(receive_lane_marker_value_reg[aw_addr_reg[4:3]][32*aw_addr_reg[2] +: 32],
                w_data_reg, w_strb_reg); // R13
      end
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr[7:6] == `PCS_MK_PAGE) begin
      rd_mux = s_axi_araddr[5] ?
               transmit_lane_marker_value_reg[s_axi_araddr[4:3]][32*s_axi_araddr[2] +: 32] :
               receive_lane_marker_value_reg[s_axi_araddr[4:3]][32*s_axi_araddr[2] +: 32];
    end else if (s_axi_araddr == `PCS_OFF_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (s_axi_araddr == `PCS_OFF_SPACE) begin
      rd_mux = {transmit_marker_spacing_reg, receive_marker_spacing_reg};
    end else if (s_axi_araddr == `PCS_OFF_STAT) begin
      rd_mux = {22'h0, fec, an_fec_advertise, startup_done, rx_fifo_error, block_lock};
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PCS_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= addr_ok(s_axi_araddr) ? `PCS_RESP_OK : `PCS_RESP_SLV;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Mode advertisement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_fec_advertise <= 2'h0;
    end else if (ce) begin
      an_fec_advertise <= ctrl_reg[`PCS_CTRL_AN_EN] ?
                          {fec == PCS_FEC_RS, fec == PCS_FEC_CYCLIC} : 2'h0; // R2 R16
    end
  end

  // Next block pair: markers, encoded word or idle
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (tx_mark) begin
        tx_blk[k] = {`PCS_SYNC_CTRL, transmit_lane_marker_value_reg[{tx_cnt_reg[0], k[0]}]}; // R13
      end else if (buf_valid) begin
        tx_blk[k] = enc64(buf_word.d[64*k +: 64], buf_word.c[8*k +: 8]); // R3 R4
      end else begin
        tx_blk[k] = `PCS_IDLE_BLK;
      end
    end
  end

  // Transmit core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_reg             <= 16'h0;
      transmit_lane_valid    <= 1'b0;
      transmit_serial_lane_p <= '0;
      transmit_serial_lane_n <= '1;
    end else if (ce) begin
      if (tx_rst) begin
        tx_cnt_reg          <= 16'h0;
        transmit_lane_valid <= 1'b0;
      end else begin
        tx_cnt_reg          <= (tx_cnt_reg >= tx_space) ? 16'h0 : tx_cnt_reg + 16'h1; // R19
        transmit_lane_valid <= 1'b1;
        transmit_serial_lane_p <= {tx_blk[1], tx_blk[0]}; // R3 R13
        transmit_serial_lane_n <= ~{tx_blk[1], tx_blk[0]}; // R15
      end
    end
  end

  // Receive marker count and block lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_reg <= 16'h0;
      block_lock <= 4'h0;
    end else if (ce) begin
      if (rx_rst) begin
        rx_cnt_reg <= 16'h0;
        block_lock <= 4'h0;
      end else if (rx_go) begin
        rx_cnt_reg <= (rx_cnt_reg >= rx_space) ? 16'h0 : rx_cnt_reg + 16'h1; // R19
        for (int k = 0; k < 2; k++) begin
          if (rx_mark) begin
            block_lock[{rx_cnt_reg[0], k[0]}] <= (receive_serial_lane_p[k] ==
              {`PCS_SYNC_CTRL, receive_lane_marker_value_reg[{rx_cnt_reg[0], k[0]}]}); // R13 R18
          end else if (receive_serial_lane_p[k][65:64] == 2'h0 ||
                       receive_serial_lane_p[k][65:64] == 2'h3) begin
            block_lock[{rx_cnt_reg[0], k[0]}] <= 1'b0; // R18
          end
        end
      end
    end
  end

  // Receive client word, replaced by each new beat even if not taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_mii_word  <= '0;
      rx_mii_valid <= 1'b0;
    end else if (ce) begin
      if (rx_cli_rst) begin
        rx_mii_valid <= 1'b0;
      end else if (rx_new) begin
        rx_mii_word  <= '{d: {dec1[71:8], dec0[71:8]}, c: {dec1[7:0], dec0[7:0]}}; // R5
        rx_mii_valid <= 1'b1;
      end else if (rx_mii_ready) begin
        rx_mii_valid <= 1'b0;
      end
    end
  end

  // Sticky slip error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_fifo_error <= 1'b0;
    end else if (ce) begin
      if (rx_cli_rst) begin
        rx_fifo_error <= 1'b0;
      end else if (rx_new && rx_mii_valid && !rx_mii_ready) begin
        rx_fifo_error <= 1'b1; // R17
      end
    end
  end

endmodule

/* hw/pcs_params.svh */
// Purpose: lane coding constants
// Assumes: 200 MHz aclk, 8-bit byte addresses
// Notes: tags below
// Function
// R1 - FEC mode is none, cyclic or RS
// R2 - FEC mode advertised to partner
// R3 - Encode and decode Base-R 64b/66b blocks
// R4 - Coding only: no FCS, pause, stream
// R5 - Receive 128-bit data, 16-bit control out
// R6 - Client sends 128-bit data, 16-bit control
// R7 - Transceiver reset restarts startup and core
// R8 - Core resets driven synchronously by controller
// R9 - Separate client-side receive and transmit resets
// R10 - Separate 16-bit spacing settings, default 16383
// R11 - RS FEC at 50G forces spacing 20479
// R12 - Change markers and spacing only in reset
// R13 - Four 64-bit markers per direction
// R14 - Separate receive and transmit cores
// R15 - Two differential lanes each direction
// R16 - FEC and autoneg optional
// R17 - Receive FIFO slip flags sticky error
// R18 - Level block lock per coding lane
// R19 - Marker every spacing plus one words
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// Timing
`define PCS_CLK_MHZ      200
`define PCS_STARTUP_NS   1000
`define PCS_STARTUP_CYC  ((`PCS_STARTUP_NS * `PCS_CLK_MHZ + 999) / 1000)

// Register byte offsets
`define PCS_OFF_CTRL     8'h00
`define PCS_OFF_SPACE    8'h04
`define PCS_OFF_STAT     8'h08
`define PCS_MK_PAGE      2'h1

// Control fields and reset value
`define PCS_CTRL_50G     2
`define PCS_CTRL_AN_EN   3
`define PCS_CTRL_RXCORE  4
`define PCS_CTRL_TXCORE  5
`define PCS_CTRL_RXCLI   6
`define PCS_CTRL_TXCLI   7
`define PCS_CTRL_XRST    8
`define PCS_CTRL_MASK    32'h0000_01FF
`define PCS_CTRL_RST     32'h0000_00F0

// Marker spacing values
`define PCS_SPACE_DEF    16'h3FFF
`define PCS_SPACE_RS50   16'h4FFF

// Block coding
`define PCS_SYNC_DATA    2'h1
`define PCS_SYNC_CTRL    2'h2
`define PCS_T_IDLE       8'h1E
`define PCS_T_START      8'h78
`define PCS_T_TERM       64'hFFE1D2CCB4AA9987
`define PCS_CH_IDLE      8'h07
`define PCS_CH_START     8'hFB
`define PCS_CH_TERM      8'hFD
`define PCS_CH_ERR       8'hFE
`define PCS_C_ERR        7'h1E
`define PCS_IDLE_BLK     66'h2_0000_0000_0000_001E

// Bus answers
`define PCS_RESP_OK      2'h0
`define PCS_RESP_SLV     2'h2

`endif

/* hw/pcs_pkg.sv */
// Purpose: lane coding types
// Assumes: constants live in pcs_params.svh
// Notes: 16 bytes, 16 control flags
package pcs_pkg;

  // Client word, byte 0 low
  typedef struct packed {
    logic [127:0] d;
    logic [15:0]  c;
  } pcs_mii_t;

  // Line block, sync in [65:64]
  typedef logic [65:0] pcs_blk_t;

  // Error correction modes
  typedef enum logic [1:0] {
    PCS_FEC_NONE,
    PCS_FEC_CYCLIC,
    PCS_FEC_RS
  } pcs_fec_t;

  // Transceiver startup states
  typedef enum logic [1:0] {
    PCS_ST_HOLD,
    PCS_ST_WAIT,
    PCS_ST_RUN
  } pcs_start_t;

endpackage

/* hw/pcs_pair_buf.sv */
// Purpose: two-entry transmit buffer
// Assumes: one clock, sync reset
// Notes: registered in_ready stalls client when full
`timescale 1ns/1ps
module pcs_pair_buf (
  // Clock and control
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ce,
  input  wire logic            flush,
  // Filling side
  input  wire pcs_pkg::pcs_mii_t in_word,
  input  wire logic            in_valid,
  output logic                 in_ready,
  // Draining side
  output pcs_pkg::pcs_mii_t    out_word,
  output logic                 out_valid,
  input  wire logic            out_ready
);
  import pcs_pkg::*;

  pcs_mii_t   slot_reg [0:1];
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       push;
  logic       pop;

  // Handshakes and occupancy
  assign out_valid = (cnt_reg != 2'h0);
  assign out_word  = slot_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign cnt_next  = cnt_reg + {1'b0, push} - {1'b0, pop};

  // Pointers, count and ready flag
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && flush)) begin
      wp_reg   <= 1'b0;
      rp_reg   <= 1'b0;
      cnt_reg  <= 2'h0;
      in_ready <= 1'b1;
    end else if (ce) begin
      wp_reg   <= wp_reg ^ push;
      rp_reg   <= rp_reg ^ pop;
      cnt_reg  <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
    end
  end

  // Storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end else if (ce && !flush && push) begin
      slot_reg[wp_reg] <= in_word;
    end
  end

endmodule

/* verification/pcs_lc_props.sv */
// Purpose: port checks
// Assumes: one clock
// Notes: ce held high by the bench
`timescale 1ns/1ps
module pcs_lc_props (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  // Read channel
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  // Line and status
  input wire pcs_pkg::pcs_blk_t [1:0] transmit_serial_lane_p,
  input wire pcs_pkg::pcs_blk_t [1:0] transmit_serial_lane_n,
  input wire logic                    transmit_lane_valid,
  input wire logic                    receive_lane_valid,
  input wire logic [3:0]              block_lock,
  input wire logic                    rx_fifo_error,
  input wire logic                    rx_mii_valid,
  input wire logic                    rx_mii_ready,
  input wire logic [1:0]              an_fec_advertise
);
  import pcs_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read request taken
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  lane_pair_a: assert property (transmit_serial_lane_n == ~transmit_serial_lane_p)
    else $error("lane halves not inverse");
  sync_head_a: assert property (transmit_lane_valid |->
    ^transmit_serial_lane_p[0][65:64] && ^transmit_serial_lane_p[1][65:64])
    else $error("bad sync header");
  rd_answer_a: assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  fec_one_a: assert property (an_fec_advertise != 2'h3)
    else $error("two fec modes");
  fifo_cause_a: assert property ($rose(rx_fifo_error) |->
    $past(rx_mii_valid) && !$past(rx_mii_ready))
    else $error("fifo error without overrun");
  lock_cause_a: assert property ($rose(block_lock[0]) |-> $past(receive_lane_valid))
    else $error("lock without beat");
  rx_cause_a: assert property ($rose(rx_mii_valid) |-> $past(receive_lane_valid))
    else $error("word without beat");
endmodule

/* verification/pcs_lc_mac.sv */
// Purpose: client model
// Assumes: same clock as the block, ce high
// Notes: keeps all-data words
`timescale 1ns/1ps
module pcs_lc_mac (
  // Clock, reset, commands
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [4:0]        n_send,
  input  wire logic              stall,
  // Client sides
  output pcs_pkg::pcs_mii_t      tx_mii_word,
  output logic                   tx_mii_valid,
  input  wire logic              tx_mii_ready,
  input  wire pcs_pkg::pcs_mii_t rx_mii_word,
  input  wire logic              rx_mii_valid,
  output logic                   rx_mii_ready
);
  import pcs_pkg::*;
  logic [4:0]   sent;
  logic [4:0]   n_got;
  logic [127:0] got [0:15];
  // Count as payload, garbage while idle
  assign tx_mii_word = {{4{27'h0, sent}}, 16'h0} ^ {144{!tx_mii_valid}};
  assign rx_mii_ready = !stall;
  // Offer words, hold each until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sent         <= 5'h00;
      tx_mii_valid <= 1'b0;
    end else begin
      if (tx_mii_valid && tx_mii_ready) sent <= sent + 5'h01;
      tx_mii_valid <= (sent + 5'(tx_mii_valid && tx_mii_ready)) < n_send;
    end
  end
  // Store data words in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_got <= 5'h00;
    end else if (rx_mii_valid && rx_mii_ready && rx_mii_word.c == 16'h0) begin
      got[n_got[3:0]] <= rx_mii_word.d;
      n_got           <= n_got + 5'h01;
    end
  end
endmodule

/* verification/pcs_lc_tb.sv */
// Purpose: lane coding bench
// Assumes: line lanes looped back, ce high
// Notes: spacing 7, short marker gaps
`include "pcs_params.svh"
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  import pcs_pkg::*;
  logic aclk = 0, aresetn = 0, xrst = 0, stall = 0, awv = 0, wv = 0, bready = 0;
  logic arv = 0, rready = 0, awr, wrdy, bv, arr, rv, tlv, ferr, sdone, txv, txr, rxv, rxr;
  logic [7:0]     awaddr = 0, araddr = 0;
  logic [31:0]    wdata = 0, rdata, d;
  logic [1:0]     bresp, rresp, adv, r;
  logic [3:0]     lock;
  logic [4:0]     n_send = 0;
  pcs_mii_t       txw, rxw;
  pcs_blk_t [1:0] lp, ln;
  int             fails = 0, n_tests = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  pcs_lane_coding uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .transceiver_reset_everything(xrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .tx_mii_word(txw),
    .tx_mii_valid(txv), .tx_mii_ready(txr), .rx_mii_word(rxw), .rx_mii_valid(rxv),
    .rx_mii_ready(rxr), .transmit_serial_lane_p(lp), .transmit_serial_lane_n(ln),
    .transmit_lane_valid(tlv), .receive_serial_lane_p(lp), .receive_serial_lane_n(ln),
    .receive_lane_valid(tlv), .block_lock(lock), .rx_fifo_error(ferr),
    .startup_done(sdone), .an_fec_advertise(adv));
  pcs_lc_mac mac (.aclk(aclk), .aresetn(aresetn), .n_send(n_send), .stall(stall),
    .tx_mii_word(txw), .tx_mii_valid(txv), .tx_mii_ready(txr),
    .rx_mii_word(rxw), .rx_mii_valid(rxv), .rx_mii_ready(rxr));
  // Verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  // Bus write, response into r
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    r = bresp;
    bready <= 0;
  endtask
  // Bus read into d and r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (!rv);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  function automatic pcs_blk_t mk(input int i);
    return {2'h2, 16'h5A5A, 16'(i), 16'hA5A5, 16'(i)};
  endfunction
  // Marker lanes and gap
  task automatic gap(input int exp);
    int n;
    n = 0;
    while (lp[0] !== mk(0)) @(posedge aclk);
    `CHK(lp[1], mk(1))
    @(posedge aclk);
    `CHK(lp[0], mk(2))
    while (lp[0] !== mk(0)) begin
      @(posedge aclk);
      n++;
    end
    `CHK(n + 1, exp)
  endtask
  task automatic wait_up();
    for (int k = 0; k < 400 && !sdone; k++) @(posedge aclk);
    `CHK(sdone, 1'b1)
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`PCS_OFF_CTRL);
    `CHK(d, `PCS_CTRL_RST)
    rd(`PCS_OFF_SPACE);
    `CHK(d, {`PCS_SPACE_DEF, `PCS_SPACE_DEF})
    rd(8'h30);
    `CHK({r, d}, {`PCS_RESP_SLV, 32'h0})
    wr(8'h30, 32'h1);
    `CHK(r, `PCS_RESP_SLV)
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h40 + 8 * i), {16'hA5A5, 16'(i % 4)});
      wr(8'(8'h44 + 8 * i), {16'h5A5A, 16'(i % 4)});
    end
    wr(`PCS_OFF_SPACE, 32'h0007_0007);
    wr(`PCS_OFF_CTRL, 32'h0);
    wait_up();
    repeat (40) @(posedge aclk);
    rd(`PCS_OFF_STAT);
    `CHK({lock, d}, {4'hF, 32'h2F})
    gap(8);
    n_send <= 5'd12;
    for (int k = 0; k < 200 && mac.n_got < 12; k++) @(posedge aclk);
    `CHK(mac.n_got, 5'd12)
    for (int i = 0; i < 12; i++) `CHK(mac.got[i], {4{27'h0, 5'(i)}})
    stall <= 1;
    repeat (20) @(posedge aclk);
    stall <= 0;
    `CHK(ferr, 1'b1)
    wr(`PCS_OFF_CTRL, 32'h40);
    wr(`PCS_OFF_CTRL, 32'h0);
    `CHK(ferr, 1'b0)
    for (int m = 0; m < 3; m++) begin
      wr(`PCS_OFF_CTRL, 32'(8 + m));
      rd(`PCS_OFF_STAT);
      `CHK({adv, d[9:8]}, {m == 2, m == 1, 2'(m)})
    end
    wr(`PCS_OFF_CTRL, 32'h36);
    wr(`PCS_OFF_CTRL, 32'h06);
    gap(int'(`PCS_SPACE_RS50) + 1);
    xrst <= 1;
    repeat (4) @(posedge aclk);
    `CHK(sdone, 1'b0)
    xrst <= 0;
    wait_up();
    end_sim();
  end
endmodule
bind pcs_lane_coding pcs_lc_props u_props (.*);
